// File: pmd_lock_pkg.sv
// constants for the module-disable lock and sleep configuration block
package pmd_lock_pkg;
   // register byte offsets
   localparam logic [7:0] cfg_ctrl_off = 8'h00;
   localparam logic [7:0] cfg_word3_off = 8'h10;
   localparam logic [7:0] mod_dis_base = 8'h20;
   // sleep registers sit clear of four module-disable blocks at 0x20..0x5F
   localparam logic [7:0] sleep_ctrl_off = 8'h80;
   localparam logic [7:0] sleep_stat_off = 8'h90;
   localparam logic [7:0] unlock_off = 8'h60;
   // alias sub-offsets
   localparam logic [1:0] alias_wr = 2'h0;
   localparam logic [1:0] alias_clr = 2'h1;
   localparam logic [1:0] alias_set = 2'h2;
   localparam logic [1:0] alias_inv = 2'h3;
   // field positions
   localparam int lock_bit = 12;
   localparam int supply_owner_bit = 31;
   localparam int ident_owner_bit = 30;
   localparam int remap_one_shot_bit = 29;
   localparam int mod_one_shot_bit = 28;
   localparam int shadow_lsb = 16;
   localparam int shadow_msb = 18;
   localparam logic [31:0] word3_impl_mask = 32'hF007FFFF;
   // reset values
   localparam logic lock_reset = 1'b1;
   localparam logic [31:0] mod_dis_reset = 32'h00000000;
   // unlock key words
   localparam logic [31:0] key_one = 32'hAA996655;
   localparam logic [31:0] key_two = 32'h556699AA;
   // wake start-up times
   localparam int clk_mhz = 50;
   localparam int wake_fast_ns = 2000;
   localparam int wake_xtal_ns = 20000;
   localparam int wake_fast_cyc = (wake_fast_ns * clk_mhz + 999) / 1000;
   localparam int wake_xtal_cyc = (wake_xtal_ns * clk_mhz + 999) / 1000;
   typedef enum logic [3:0] {
      st_run = 4'h1,
      st_sleep = 4'h2,
      st_wake = 4'h4,
      st_resume = 4'h8
   } pwr_state_t;
endpackage

// File: unlock_seq.sv
// two-key unlock sequencer for protected control bits
`timescale 1ns/10ps
module unlock_seq (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // key writes
   input wire logic key_wr,
   input wire logic [31:0] key_data,
   input wire logic relock,
   // state
   output logic unlocked
);
   import pmd_lock_pkg::*;
   logic first_r;
   logic unlocked_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_r <= 1'b0;
         unlocked_r <= 1'b0;
      end else if (clk_en) begin
         if (relock) begin
            first_r <= 1'b0;
            unlocked_r <= 1'b0;
         end else if (key_wr) begin
            first_r <= (key_data == key_one);
            if (first_r && key_data == key_two)
               unlocked_r <= 1'b1;
            else if (key_data != key_two)
               unlocked_r <= 1'b0;
         end
      end
   end
   assign unlocked = unlocked_r;
endmodule

// File: wake_timer.sv
// start-up delay counter for leaving sleep
`timescale 1ns/10ps
module wake_timer #(
   parameter int fast_cyc = 100,
   parameter int xtal_cyc = 1000
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // control
   input wire logic start,
   input wire logic xtal_sel,
   // status
   output logic done
);
   logic [15:0] cnt_r;
   logic run_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 16'h0000;
         run_r <= 1'b0;
      end else if (clk_en) begin
         if (start) begin
            cnt_r <= xtal_sel ? 16'(xtal_cyc - 1) : 16'(fast_cyc - 1);
            run_r <= 1'b1;
         end else if (run_r) begin
            if (cnt_r == 16'h0000)
               run_r <= 1'b0;
            else
               cnt_r <= cnt_r - 16'h0001;
         end
      end
   end
   assign done = run_r && (cnt_r == 16'h0000);
endmodule

// File: pmd_lock_cfg.sv
// module-disable write lock, configuration word three and sleep control
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module pmd_lock_cfg #(
   parameter int num_mod_dis = 4,
   parameter logic [31:0] word3_value = 32'h00000000
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // configuration word as read from fuses
   input wire logic [31:0] fuse_word3,
   // configuration outputs
   output logic [31:0] mod_disable [num_mod_dis],
   output logic module_disable_write_lock,
   output logic usb_supply_pin_owner,
   output logic usb_ident_pin_owner,
   output logic pin_remap_one_shot,
   output logic [2:0] shadow_set_priority_select,
   output logic [15:0] user_identifier_field,
   // sleep
   input wire logic usb_osc_request,
   input wire logic wake_request,
   input wire logic [15:0] pin_out_run,
   output logic [15:0] pin_out,
   output logic cpu_halt,
   output logic clock_monitor_enable,
   output logic brown_out_detector_enable,
   output logic watchdog_counter_clear,
   output logic osc_main_enable,
   output logic low_power_domain_enable
);
   import pmd_lock_pkg::*;

   pwr_state_t state_r;
   logic lock_r;
   logic one_shot_r;
   logic sampled_r;
   logic [31:0] word3_r;
   logic xtal_sel_r;
   logic [31:0] mod_dis_r [num_mod_dis];
   logic [15:0] pin_hold_r;
   logic [31:0] prdata_r;
   logic unlocked;
   logic wake_done;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] base_addr;
   logic [1:0] alias_sel;

   assign wr_acc = psel && penable && pwrite && clk_en;
   assign rd_acc = psel && !penable && !pwrite && clk_en;
   assign base_addr = {paddr[7:4], 4'h0};
   assign alias_sel = paddr[3:2];
   // one wait-free access phase; every access, blocked or not, is acknowledged
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // apply a write or alias to a 32-bit value
   function automatic logic [31:0] alias_apply(input logic [31:0] cur, input logic [1:0] sel,
                                               input logic [31:0] d);
      logic [31:0] res;
      res = cur;
      case (sel)
         alias_wr: res = d;
         alias_clr: res = cur & ~d;
         alias_set: res = cur | d;
         alias_inv: res = cur ^ d;
         default: res = cur;
      endcase
      return res;
   endfunction

   unlock_seq u_unlock (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .key_wr(wr_acc && paddr == unlock_off),
      .key_data(pwdata),
      .relock(wr_acc && base_addr == cfg_ctrl_off),
      .unlocked(unlocked)
   );

   // fuse snapshot after reset release; later fuse changes wait for reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sampled_r <= 1'b0;
         one_shot_r <= 1'b0;
         word3_r <= 32'h00000000;
      end else if (clk_en && !sampled_r) begin
         sampled_r <= 1'b1;
         one_shot_r <= fuse_word3[mod_one_shot_bit];
         word3_r <= (fuse_word3 | word3_value) & word3_impl_mask;
      end
   end

   // lock bit in configuration control
   logic lock_nxt;
   logic [31:0] lock_word;
   always_comb begin
      lock_word = alias_apply({19'h00000, lock_r, 12'h000}, alias_sel, pwdata);
      lock_nxt = lock_word[lock_bit];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_r <= lock_reset;
      end else if (clk_en && wr_acc && base_addr == cfg_ctrl_off && unlocked) begin
         if (lock_nxt || !one_shot_r)
            lock_r <= lock_nxt;
      end
   end

   // module-disable registers
   genvar gi;
   generate
      for (gi = 0; gi < num_mod_dis; gi++) begin : g_md
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               mod_dis_r[gi] <= mod_dis_reset;
            else if (wr_acc && !lock_r && base_addr == 8'(mod_dis_base + 8'(gi * 16)))
               mod_dis_r[gi] <= alias_apply(mod_dis_r[gi], alias_sel, pwdata);
         end
         assign mod_disable[gi] = mod_dis_r[gi];
      end
   endgenerate

   // sleep control
   logic sleep_cmd;
   assign sleep_cmd = wr_acc && paddr == sleep_ctrl_off && pwdata[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         xtal_sel_r <= 1'b0;
      else if (clk_en && wr_acc && paddr == sleep_ctrl_off)
         xtal_sel_r <= pwdata[1];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= st_run;
      end else if (clk_en) begin
         case (state_r)
            st_run: if (sleep_cmd) state_r <= st_sleep;
            st_sleep: if (wake_request) state_r <= st_wake;
            st_wake: state_r <= st_resume;
            st_resume: if (wake_done) state_r <= st_run;
            default: state_r <= st_run;
         endcase
      end
   end
   wake_timer #(
      .fast_cyc(wake_fast_cyc),
      .xtal_cyc(wake_xtal_cyc)
   ) u_wake (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .start(state_r == st_wake),
      .xtal_sel(xtal_sel_r),
      .done(wake_done)
   );

   // pins follow run-time value only while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pin_hold_r <= 16'h0000;
      else if (clk_en && state_r == st_run)
         pin_hold_r <= pin_out_run;
   end
   assign pin_out = pin_hold_r;

   assign cpu_halt = (state_r != st_run);
   assign clock_monitor_enable = (state_r == st_run);
   assign brown_out_detector_enable = 1'b1;
   assign watchdog_counter_clear = 1'b0;
   assign osc_main_enable = (state_r != st_sleep) || usb_osc_request;
   assign low_power_domain_enable = 1'b1;

   assign module_disable_write_lock = lock_r;
   assign usb_supply_pin_owner = word3_r[supply_owner_bit];
   assign usb_ident_pin_owner = word3_r[ident_owner_bit];
   assign pin_remap_one_shot = word3_r[remap_one_shot_bit];
   assign shadow_set_priority_select = word3_r[shadow_msb:shadow_lsb];
   assign user_identifier_field = word3_r[15:0];

   // read data, taken in setup and held through access
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h00000000;
      if (base_addr == cfg_ctrl_off)
         rd_val = {19'h00000, lock_r, 12'h000};
      else if (base_addr == cfg_word3_off)
         rd_val = word3_r;
      else if (paddr == sleep_stat_off)
         rd_val = {26'h0000000, one_shot_r, unlocked, state_r};
      else if (paddr == sleep_ctrl_off)
         rd_val = {30'h00000000, xtal_sel_r, 1'b0};
      for (int i = 0; i < num_mod_dis; i++)
         if (base_addr == 8'(mod_dis_base + 8'(i * 16)))
            rd_val = mod_dis_r[i];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_r <= 32'h00000000;
      else if (rd_acc)
         prdata_r <= rd_val;
   end
   assign prdata = prdata_r;

   a_locked_hold: assert property (@(posedge pclk) disable iff (!presetn)
      lock_r |=> $stable(mod_dis_r[0]) || $past(!lock_r))
      else $error("module-disable register changed while locked");
   a_no_error: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable |-> pready && !pslverr)
      else $error("access not completed cleanly");
   a_lock_key: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(unlocked) && $past(sampled_r) |-> $stable(lock_r))
      else $error("lock changed without unlock");
   a_one_way: assert property (@(posedge pclk) disable iff (!presetn)
      one_shot_r && sampled_r && $past(one_shot_r) && $past(lock_r) |-> lock_r)
      else $error("lock cleared under one-shot");
   a_word_zero: assert property (@(posedge pclk) disable iff (!presetn)
      word3_r[27:19] == 9'h000)
      else $error("unimplemented bits nonzero");
   a_sleep_halt: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == st_sleep |-> cpu_halt && !clock_monitor_enable && brown_out_detector_enable)
      else $error("sleep outputs wrong");
   a_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_r == st_sleep |=> $stable(pin_out))
      else $error("pins moved in sleep");
   a_usb_osc: assert property (@(posedge pclk) disable iff (!presetn)
      usb_osc_request |-> osc_main_enable)
      else $error("oscillator stopped despite usb request");
   a_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_r == st_resume) && clk_en |=> state_r == st_resume)
      else $error("resumed without start-up delay");

   // every module-disable register holds while the lock is set
   generate
      for (gi = 0; gi < num_mod_dis; gi++) begin : g_md_chk
         a_md_hold: assert property (@(posedge pclk) disable iff (!presetn)
            lock_r |=> $stable(mod_dis_r[gi]))
            else $error("module-disable register changed while locked");
      end
   endgenerate
   a_md_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && !lock_r && paddr == mod_dis_base |=> mod_dis_r[0] == $past(pwdata))
      else $error("open module-disable write lost");
   a_alias_clr: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && !lock_r && paddr == mod_dis_base + 8'h04 |=> mod_dis_r[0] == ($past(mod_dis_r[0]) & ~$past(pwdata)))
      else $error("clear alias wrong");
   a_alias_set: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && !lock_r && paddr == mod_dis_base + 8'h08 |=> mod_dis_r[0] == ($past(mod_dis_r[0]) | $past(pwdata)))
      else $error("set alias wrong");
   a_alias_inv: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && !lock_r && paddr == mod_dis_base + 8'h0C |=> mod_dis_r[0] == ($past(mod_dis_r[0]) ^ $past(pwdata)))
      else $error("invert alias wrong");
   a_relock: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && base_addr == cfg_ctrl_off |=> !unlocked)
      else $error("key survived a control write");
   a_lock_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && base_addr == cfg_ctrl_off && unlocked && !one_shot_r |=> lock_r == $past(lock_nxt))
      else $error("unlocked lock write not applied");
   a_lock_reset: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sampled_r) |-> lock_r)
      else $error("lock not set after reset");
   a_fuse_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      sampled_r && $past(sampled_r) |-> $stable(word3_r) && $stable(one_shot_r))
      else $error("fuse snapshot changed without reset");

   // fields follow the fuse value taken at the snapshot edge
   a_supply_owner: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sampled_r) |-> usb_supply_pin_owner == ($past(fuse_word3[supply_owner_bit]) | word3_value[supply_owner_bit]))
      else $error("supply pin owner wrong");
   a_ident_owner: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sampled_r) |-> usb_ident_pin_owner == ($past(fuse_word3[ident_owner_bit]) | word3_value[ident_owner_bit]))
      else $error("identity pin owner wrong");
   a_remap_bit: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sampled_r) |-> pin_remap_one_shot == ($past(fuse_word3[remap_one_shot_bit]) | word3_value[remap_one_shot_bit]))
      else $error("remap one-shot bit wrong");
   a_shadow_map: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sampled_r) |-> shadow_set_priority_select == ($past(fuse_word3[shadow_msb:shadow_lsb]) | word3_value[shadow_msb:shadow_lsb]))
      else $error("shadow priority wrong");
   a_user_ident: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sampled_r) |-> user_identifier_field == ($past(fuse_word3[15:0]) | word3_value[15:0]))
      else $error("user identifier wrong");

   // sleep steps: entry, one wake cycle, then the start-up count
   sequence sleep_seen_s;
      state_r == st_run && sleep_cmd;
   endsequence
   sequence wake_seen_s;
      state_r == st_sleep && wake_request && clk_en ##1 clk_en;
   endsequence
   sequence wake_hop_s;
      state_r == st_wake ##1 state_r == st_resume;
   endsequence
   a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
      sleep_seen_s |=> state_r == st_sleep)
      else $error("sleep not entered");
   a_wake_steps: assert property (@(posedge pclk) disable iff (!presetn)
      wake_seen_s |-> wake_hop_s)
      else $error("wake steps out of order");
   a_resume_done: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == st_resume && wake_done && clk_en |=> state_r == st_run)
      else $error("no return to run after start-up");
   a_halt_run: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == st_run |-> !cpu_halt && clock_monitor_enable)
      else $error("run outputs wrong");
   a_osc_off: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == st_sleep && !usb_osc_request |-> !osc_main_enable)
      else $error("oscillator kept without usb request");
   a_keep_alive: assert property (@(posedge pclk) disable iff (!presetn)
      !watchdog_counter_clear && low_power_domain_enable && brown_out_detector_enable)
      else $error("always-on outputs wrong");
   a_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(state_r) && $stable(lock_r) && $stable(pin_out))
      else $error("state moved with clock enable low");
endmodule

// File: test_module_disable_lock_and_sleep_cfg.sv
// self-checking bench for the module-disable lock, configuration word and sleep block
`timescale 1ns/10ps
module test_module_disable_lock_and_sleep_cfg;
   import pmd_lock_pkg::*;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, fuse_word3, seed, rd, f, d, e;
   logic [31:0] mod_disable [4];
   logic [31:0] ex [4];
   logic lock_o, sup_o, id_o, remap_o, usb_osc_request, wake_request;
   logic cpu_halt, mon_en, bod_en, wdt_clr, osc_en, lp_en;
   logic [2:0] shadow_o;
   logic [15:0] user_o, pin_out_run, pin_out, pv;
   int err_count, total_checks, n;

   pmd_lock_cfg pmd_lock_cfg_inst (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fuse_word3(fuse_word3), .mod_disable(mod_disable),
      .module_disable_write_lock(lock_o), .usb_supply_pin_owner(sup_o), .usb_ident_pin_owner(id_o),
      .pin_remap_one_shot(remap_o), .shadow_set_priority_select(shadow_o),
      .user_identifier_field(user_o), .usb_osc_request(usb_osc_request), .wake_request(wake_request),
      .pin_out_run(pin_out_run), .pin_out(pin_out), .cpu_halt(cpu_halt),
      .clock_monitor_enable(mon_en), .brown_out_detector_enable(bod_en),
      .watchdog_counter_clear(wdt_clr), .osc_main_enable(osc_en), .low_power_domain_enable(lp_en)
   );

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [31:0] alias_fn(input logic [31:0] o, input int op, input logic [31:0] v);
      case (op)
         0: return v;
         1: return o & ~v;
         2: return o | v;
         default: return o ^ v;
      endcase
   endfunction

   task summarize();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // caller stands just after a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_count++;
         $display("Error at %0t: no pready", $time);
      end
      r = prdata;
      chk(pslverr, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge: next call never reassigns psel in this step, outputs settle
      @(posedge pclk);
   endtask

   task unlock();
      apb(1'b1, unlock_off, key_one, rd);
      apb(1'b1, unlock_off, key_two, rd);
   endtask

   task do_reset(input logic [31:0] fw);
      presetn <= 1'b0;
      fuse_word3 <= fw;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   task chk_word(input logic [31:0] fw);
      apb(1'b0, cfg_word3_off, 32'h0, rd);
      chk(rd, fw & word3_impl_mask);
      chk(sup_o, fw[supply_owner_bit]);
      chk(id_o, fw[ident_owner_bit]);
      chk(remap_o, fw[remap_one_shot_bit]);
      chk(shadow_o, fw[shadow_msb:shadow_lsb]);
      chk(user_o, fw[15:0]);
   endtask

   initial begin
      #400000;
      err_count++;
      summarize();
   end

   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fuse_word3 = 32'h0;
      usb_osc_request = 1'b0;
      wake_request = 1'b0;
      pin_out_run = 16'h0;
      seed = 32'h000043CD;
      // every shadow code, one-shot fuse alternating so a reset must undo the freeze
      for (int k = 0; k < 8; k++) begin
         f = rnd();
         f[18:16] = k[2:0];
         f[28] = k[0];
         do_reset(f);
         chk(lock_o, lock_reset);
         chk_word(f);
         apb(1'b1, mod_dis_base, rnd(), rd);
         apb(1'b0, mod_dis_base, 32'h0, rd);
         chk(rd, mod_dis_reset);
         apb(1'b1, cfg_ctrl_off, 32'h0, rd);
         chk(lock_o, 1'b1);
         unlock();
         apb(1'b1, cfg_ctrl_off, 32'h0, rd);
         chk(lock_o, f[28]);
         d = rnd();
         apb(1'b1, mod_dis_base, d, rd);
         apb(1'b0, mod_dis_base, 32'h0, rd);
         chk(rd, f[28] ? mod_dis_reset : d);
         fuse_word3 <= ~f;
         apb(1'b0, cfg_word3_off, 32'h0, rd);
         chk(rd, f & word3_impl_mask);
      end
      f = rnd() & 32'hEFFFFFFF;
      do_reset(f);
      unlock();
      apb(1'b1, cfg_ctrl_off + 8'h04, 32'h00001000, rd);
      chk(lock_o, 1'b0);
      for (int i = 0; i < 4; i++) begin
         ex[i] = mod_dis_reset;
         for (int op = 0; op < 4; op++) begin
            d = rnd();
            apb(1'b1, mod_dis_base + 8'(16 * i) + 8'(4 * op), d, rd);
            ex[i] = alias_fn(ex[i], op, d);
            apb(1'b0, mod_dis_base + 8'(16 * i), 32'h0, rd);
            chk(rd, ex[i]);
            chk(mod_disable[i], ex[i]);
         end
      end
      unlock();
      apb(1'b1, cfg_ctrl_off + 8'h08, 32'h00001000, rd);
      chk(lock_o, 1'b1);
      apb(1'b1, cfg_ctrl_off + 8'h0C, 32'h00001000, rd);
      chk(lock_o, 1'b1);
      for (int op = 0; op < 4; op++) begin
         apb(1'b1, mod_dis_base + 8'(4 * op), rnd(), rd);
         chk(mod_disable[0], ex[0]);
      end
      // unmapped place reads zero and ignores writes
      apb(1'b1, 8'h70, rnd(), rd);
      apb(1'b0, 8'h70, 32'h0, rd);
      chk(rd, 32'h0);
      // clock enable low: run-time pin value must not be captured
      clk_en <= 1'b0;
      pin_out_run <= 16'hA5A5;
      repeat (3) @(posedge pclk);
      chk(pin_out, 16'h0000);
      clk_en <= 1'b1;
      @(posedge pclk);
      for (int x = 0; x < 2; x++) begin
         d = rnd();
         pin_out_run <= d[15:0];
         pv = d[15:0];
         repeat (2) @(posedge pclk);
         chk(pin_out, pv);
         apb(1'b1, sleep_ctrl_off, (x == 1) ? 32'h3 : 32'h1, rd);
         usb_osc_request <= 1'b0;
         pin_out_run <= ~pv;
         repeat (2) @(posedge pclk);
         chk(cpu_halt, 1'b1);
         chk(mon_en, 1'b0);
         chk(bod_en, 1'b1);
         chk(wdt_clr, 1'b0);
         chk(lp_en, 1'b1);
         chk(osc_en, 1'b0);
         chk(pin_out, pv);
         apb(1'b0, sleep_ctrl_off, 32'h0, rd);
         chk(rd, (x == 1) ? 32'h00000002 : 32'h00000000);
         apb(1'b0, sleep_stat_off, 32'h0, rd);
         chk(rd, {28'h0000000, st_sleep});
         usb_osc_request <= 1'b1;
         @(posedge pclk);
         chk(osc_en, 1'b1);
         wake_request <= 1'b1;
         n = 0;
         while (cpu_halt === 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
         end
         wake_request <= 1'b0;
         usb_osc_request <= 1'b0;
         e = (x == 1) ? wake_xtal_cyc : wake_fast_cyc;
         // state-machine hops add a few cycles on top of the start-up count
         chk(n >= e && n <= e + 4, 1'b1);
      end
      summarize();
   end
endmodule
